// file: rtl/adc_acquire_convert_sequencer.sv
/*
 * Acquisition and conversion sequencer of a 10-bit successive-approximation
 * converter, with an AXI4-Lite register slave.
 * Assumes a comparator output from the analog side (asynchronous) and a
 * sample switch plus trial DAC driven from here; one clock, aclk.
 */
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
// Functional notes
// R1: software samples long enough after channel change
// R2: hold capacitor disconnects when conversion begins
// R3: acquisition select field at bits 5:3
// R4: nonzero select: sample, then convert automatically
// R5: select 000: go starts conversion at once
// R6: manual mode: software times acquisition itself
// R7: acquisition select resets to 000
// R8: completion clears go, sets done, resumes sampling
// R9: no status separates acquisition from conversion
// R10: conversion lasts exactly eleven bit periods
// R11: clock select maps divider codes, x11 RC
// R12: software picks shortest legal bit period
// R13: RC above 1 MHz needs sleep
// R14: RC bit period 1.2 or 2.5 us
// R15: acquisition codes map to 0..20 periods
// R16: result loads with go clear
// R17: two bit periods before next acquisition
// R18: RC clock adds one instruction cycle delay
// R19: intervals counted in whole bit periods
// R20: field writes affect only next start
`timescale 1ns/1ns
`include "adc_seq_params.svh"

module adc_acquire_convert_sequencer
#(
    parameter bit LOW_POWER = 1'b0
)
(
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // write address
    input  wire logic [`AXI_ADDR_W-1:0] awaddr,
    input  wire logic [2:0]             awprot,
    input  wire logic                   awvalid,
    output      logic                   awready,
    // write data
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output      logic                   wready,
    // write response
    output      logic [1:0]             bresp,
    output      logic                   bvalid,
    input  wire logic                   bready,
    // read address
    input  wire logic [`AXI_ADDR_W-1:0] araddr,
    input  wire logic [2:0]             arprot,
    input  wire logic                   arvalid,
    output      logic                   arready,
    // read data
    output      logic [31:0]            rdata,
    output      logic [1:0]             rresp,
    output      logic                   rvalid,
    input  wire logic                   rready,
    // analog side
    input  wire logic                   comp_in,
    output      logic                   hold_connect,
    output      logic [9:0]             dac_code,
    output      logic                   conv_busy
);
    import adc_seq_pkg::*;

    localparam logic [2:0] IDX_NONE = 3'h0;
    localparam logic [2:0] IDX_CT2  = 3'h1;
    localparam logic [2:0] IDX_CTL  = 3'h2;
    localparam logic [2:0] IDX_STAT = 3'h3;
    localparam logic [2:0] IDX_RES  = 3'h4;

    seq_regs_t s_reg;
    seq_regs_t s_next;
    logic      tick;
    logic      complete;

    // oscillator periods per bit period
    function automatic logic [7:0] tad_clks(input logic [2:0] sel);
        case (sel)
            3'h0:    tad_clks = 8'h02; // R11
            3'h4:    tad_clks = 8'h04;
            3'h1:    tad_clks = 8'h08;
            3'h5:    tad_clks = 8'h10;
            3'h2:    tad_clks = 8'h20;
            3'h6:    tad_clks = 8'h40;
            default: tad_clks = LOW_POWER ? 8'(`RC_TAD_LP_CLKS) : 8'(`RC_TAD_STD_CLKS); // R14
        endcase
    endfunction : tad_clks

    // bit periods of programmed acquisition
    function automatic logic [4:0] acq_tads(input logic [2:0] sel);
        case (sel)
            3'h1:    acq_tads = 5'h02; // R15
            3'h2:    acq_tads = 5'h04;
            3'h3:    acq_tads = 5'h06;
            3'h4:    acq_tads = 5'h08;
            3'h5:    acq_tads = 5'h0C;
            3'h6:    acq_tads = 5'h10;
            3'h7:    acq_tads = 5'h14;
            default: acq_tads = 5'h00;
        endcase
    endfunction : acq_tads

    function automatic logic [2:0] reg_index(input logic [`AXI_ADDR_W-1:0] addr);
        logic [`AXI_ADDR_W-1:0] a;
        a = {addr[`AXI_ADDR_W-1:2], 2'b00};
        if (a == `ADDR_CONTROL_TWO)
            reg_index = IDX_CT2;
        else if (a == `ADDR_CONTROL)
            reg_index = IDX_CTL;
        else if (a == `ADDR_STATUS)
            reg_index = IDX_STAT;
        else if (a == `ADDR_RESULT)
            reg_index = IDX_RES;
        else
            reg_index = IDX_NONE;
    endfunction : reg_index

    function automatic logic is_rc(input logic [2:0] sel);
        is_rc = (sel[1:0] == 2'b11);
    endfunction : is_rc

    // end of a bit period, from the latched clock select
    // comparator arrives through two flops: codes settle only from 4-clock periods up
    assign tick = (s_reg.div_cnt == tad_clks(s_reg.lat_clk) - 8'h01); // R19
    assign complete = (s_reg.state == ST_CONV) && s_reg.go && tick
                      && (s_reg.tad_cnt == 5'(`CONV_TADS - 1));

    always_comb
    begin
        logic       go_set;
        logic       go_clr;
        logic       done_clr;
        logic [2:0] widx;
        logic [3:0] bit_i;
        go_set   = 1'b0;
        go_clr   = 1'b0;
        done_clr = 1'b0;
        widx     = reg_index(s_reg.waddr);
        bit_i    = 4'h0;
        s_next   = s_reg;

        s_next.comp_s1 = comp_in;
        s_next.comp_s2 = s_reg.comp_s1;

        // write channel
        if (awvalid && s_reg.awready)
        begin
            s_next.aw_got  = 1'b1;
            s_next.waddr   = awaddr;
            s_next.awready = 1'b0;
        end
        if (wvalid && s_reg.wready)
        begin
            s_next.w_got  = 1'b1;
            s_next.wdata  = wdata;
            s_next.wstrb  = wstrb;
            s_next.wready = 1'b0;
        end
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid)
        begin
            s_next.aw_got = 1'b0;
            s_next.w_got  = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp  = (widx == IDX_NONE) ? `RESP_DECERR : `RESP_OKAY;
            if (s_reg.wstrb[0])
            begin
                case (widx)
                    IDX_CT2:
                    begin
                        s_next.acq_sel = s_reg.wdata[`CT2_ACQ_LSB +: 3]; // R3
                        s_next.clk_sel = s_reg.wdata[`CT2_CLK_LSB +: 3];
                    end
                    IDX_CTL:
                    begin
                        go_set = s_reg.wdata[`CTL_GO_BIT];
                        go_clr = !s_reg.wdata[`CTL_GO_BIT];
                    end
                    IDX_STAT: done_clr = s_reg.wdata[`STAT_DONE_BIT];
                    default:  go_set = 1'b0;
                endcase
            end
        end
        if (s_reg.bvalid && bready)
        begin
            s_next.bvalid  = 1'b0;
            s_next.awready = 1'b1;
            s_next.wready  = 1'b1;
        end

        // read channel
        if (arvalid && s_reg.arready)
        begin
            s_next.arready = 1'b0;
            s_next.rvalid  = 1'b1;
            s_next.rresp   = `RESP_OKAY;
            s_next.rdata   = 32'h0000_0000;
            case (reg_index(araddr))
                IDX_CT2:  s_next.rdata[5:0] = {s_reg.acq_sel, s_reg.clk_sel};
                IDX_CTL:  s_next.rdata[`CTL_GO_BIT] = s_reg.go; // R9
                IDX_STAT: s_next.rdata[`STAT_DONE_BIT] = s_reg.done_flag;
                IDX_RES:  s_next.rdata[9:0] = s_reg.result;
                default:  s_next.rresp = `RESP_DECERR;
            endcase
        end
        if (s_reg.rvalid && rready)
        begin
            s_next.rvalid  = 1'b0;
            s_next.arready = 1'b1;
        end

        // go flag: a software set beats the hardware clear
        if (go_set)
            s_next.go = 1'b1;
        else if (go_clr || complete)
            s_next.go = 1'b0; // R8
        s_next.done_flag = (s_reg.done_flag && !done_clr) || complete; // R8

        // bit period divider runs outside idle and the RC start delay
        if (s_reg.state != ST_IDLE)
            s_next.div_cnt = tick ? 8'h00 : s_reg.div_cnt + 8'h01;

        case (s_reg.state)
            ST_IDLE:
            begin
                s_next.hold_connect = 1'b1;
                if (s_reg.go)
                begin
                    s_next.lat_acq = s_reg.acq_sel; // R20
                    s_next.lat_clk = s_reg.clk_sel;
                    s_next.div_cnt = 8'h00;
                    s_next.tad_cnt = 5'h00;
                    s_next.dly_cnt = 3'h0;
                    if (is_rc(s_reg.clk_sel))
                        s_next.state = ST_RC_DELAY; // R18
                    else if (s_reg.acq_sel != 3'h0)
                        s_next.state = ST_ACQ; // R4
                    else
                    begin
                        s_next.state        = ST_CONV; // R5
                        s_next.hold_connect = 1'b0;
                        s_next.sar          = `SAR_FIRST_TRIAL;
                    end
                end
            end
            ST_RC_DELAY:
            begin
                s_next.div_cnt = 8'h00;
                s_next.dly_cnt = s_reg.dly_cnt + 3'h1;
                if (!s_reg.go)
                begin
                    s_next.state        = ST_RECOVER;
                    s_next.hold_connect = 1'b0;
                end
                else if (s_reg.dly_cnt == 3'(`INSTR_CYCLE_CLKS - 1))
                begin
                    if (s_reg.lat_acq != 3'h0)
                        s_next.state = ST_ACQ;
                    else
                    begin
                        s_next.state        = ST_CONV;
                        s_next.hold_connect = 1'b0;
                        s_next.sar          = `SAR_FIRST_TRIAL;
                    end
                end
            end
            ST_ACQ:
            begin
                if (!s_reg.go)
                begin
                    s_next.state        = ST_RECOVER;
                    s_next.hold_connect = 1'b0;
                    s_next.tad_cnt      = 5'h00;
                    s_next.div_cnt      = 8'h00;
                end
                else if (tick)
                begin
                    s_next.tad_cnt = s_reg.tad_cnt + 5'h01;
                    if (s_reg.tad_cnt == acq_tads(s_reg.lat_acq) - 5'h01)
                    begin
                        s_next.state        = ST_CONV; // R4
                        s_next.hold_connect = 1'b0; // R2
                        s_next.tad_cnt      = 5'h00;
                        s_next.sar          = `SAR_FIRST_TRIAL;
                    end
                end
            end
            ST_CONV:
            begin
                if (!s_reg.go)
                begin
                    // abort keeps the previous result
                    s_next.state   = ST_RECOVER;
                    s_next.tad_cnt = 5'h00;
                    s_next.div_cnt = 8'h00;
                end
                else if (tick)
                begin
                    s_next.tad_cnt = s_reg.tad_cnt + 5'h01;
                    if (complete)
                    begin
                        s_next.result  = s_reg.sar; // R16
                        s_next.state   = ST_RECOVER; // R10
                        s_next.tad_cnt = 5'h00;
                    end
                    else if (s_reg.tad_cnt < 5'h0A)
                    begin
                        bit_i = 4'(5'h09 - s_reg.tad_cnt);
                        s_next.sar[bit_i] = s_reg.comp_s2;
                        if (bit_i != 4'h0)
                            s_next.sar[bit_i - 4'h1] = 1'b1;
                    end
                end
            end
            ST_RECOVER:
            begin
                if (tick)
                begin
                    s_next.tad_cnt = s_reg.tad_cnt + 5'h01;
                    if (s_reg.tad_cnt == 5'(`RECOVER_TADS - 1))
                    begin
                        s_next.state        = ST_IDLE; // R17
                        s_next.hold_connect = 1'b1; // R8
                    end
                end
            end
            default:
            begin
                s_next.state        = ST_IDLE;
                s_next.hold_connect = 1'b1;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_reg              <= '0;
            s_reg.state        <= ST_IDLE;
            s_reg.acq_sel      <= `ACQ_SEL_RESET; // R7
            s_reg.clk_sel      <= `CLK_SEL_RESET;
            s_reg.hold_connect <= 1'b1;
            s_reg.awready      <= 1'b1;
            s_reg.wready       <= 1'b1;
            s_reg.arready      <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    assign awready      = s_reg.awready;
    assign wready       = s_reg.wready;
    assign bvalid       = s_reg.bvalid;
    assign bresp        = s_reg.bresp;
    assign arready      = s_reg.arready;
    assign rvalid       = s_reg.rvalid;
    assign rresp        = s_reg.rresp;
    assign rdata        = s_reg.rdata;
    assign hold_connect = s_reg.hold_connect;
    assign dac_code     = s_reg.sar;
    assign conv_busy    = s_reg.go;

    // checks
    default clocking cb @(posedge aclk); endclocking

    property p_reset_acq;
        !aresetn |=> (s_reg.acq_sel == 3'h0);
    endproperty
    a_reset_acq: assert property (p_reset_acq) else $error("acquisition select not cleared by reset"); // R7

    property p_hold_off_conv;
        disable iff (!aresetn) (s_reg.state == ST_CONV) |-> !hold_connect;
    endproperty
    a_hold_off_conv: assert property (p_hold_off_conv) else $error("hold capacitor connected in conversion"); // R2

    property p_manual_start;
        disable iff (!aresetn)
        (s_reg.state == ST_IDLE && s_reg.go && s_reg.acq_sel == 3'h0 && !is_rc(s_reg.clk_sel))
        |=> (s_reg.state == ST_CONV) && !hold_connect;
    endproperty
    a_manual_start: assert property (p_manual_start) else $error("manual start not immediate"); // R5

    property p_auto_start;
        disable iff (!aresetn)
        (s_reg.state == ST_IDLE && s_reg.go && s_reg.acq_sel != 3'h0 && !is_rc(s_reg.clk_sel))
        |=> (s_reg.state == ST_ACQ) && hold_connect;
    endproperty
    a_auto_start: assert property (p_auto_start) else $error("programmed acquisition not entered"); // R4

    property p_rc_delay;
        disable iff (!aresetn)
        (s_reg.state == ST_IDLE && s_reg.go && is_rc(s_reg.clk_sel))
        |=> (s_reg.state == ST_RC_DELAY)[*4] ##1 (s_reg.state != ST_RC_DELAY);
    endproperty
    a_rc_delay: assert property (p_rc_delay) else $error("rc start delay not one instruction cycle"); // R18

    property p_complete;
        disable iff (!aresetn)
        complete |=> !s_reg.go && s_reg.done_flag && (s_reg.result == $past(s_reg.sar))
                     && (s_reg.state == ST_RECOVER);
    endproperty
    a_complete: assert property (p_complete) else $error("completion effects missing"); // R8

    property p_eleven;
        disable iff (!aresetn)
        complete |-> (s_reg.tad_cnt == 5'h0A) && (s_reg.div_cnt == tad_clks(s_reg.lat_clk) - 8'h01);
    endproperty
    a_eleven: assert property (p_eleven) else $error("conversion length not eleven bit periods"); // R10

    property p_recover;
        disable iff (!aresetn)
        $rose(s_reg.state == ST_RECOVER) |-> !hold_connect ##1 (!hold_connect)[*3];
    endproperty
    a_recover: assert property (p_recover) else $error("sampling resumed too early"); // R17

    property p_latched;
        disable iff (!aresetn)
        (s_reg.state == ST_CONV) && $past(s_reg.state == ST_CONV) |-> $stable(s_reg.lat_clk);
    endproperty
    a_latched: assert property (p_latched) else $error("clock select changed mid conversion"); // R20

    c_manual: cover property (@(posedge aclk) complete && s_reg.lat_acq == 3'h0);
    c_auto:   cover property (@(posedge aclk) complete && s_reg.lat_acq != 3'h0);
    c_rc:     cover property (@(posedge aclk) complete && is_rc(s_reg.lat_clk));
    c_abort:  cover property (@(posedge aclk) s_reg.state == ST_CONV && !s_reg.go);

endmodule : adc_acquire_convert_sequencer

// file: rtl/adc_seq_params.svh
/*
 * Constants of the converter sequencer: register offsets, field positions,
 * reset values and timing counts.
 * Assumes a 20 MHz aclk that also serves as the oscillator clock.
 */
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// bus
`define AXI_ADDR_W          12
`define ADDR_CONTROL_TWO    12'h000
`define ADDR_CONTROL        12'h004
`define ADDR_STATUS         12'h008
`define ADDR_RESULT         12'h00C
`define RESP_OKAY           2'h0
`define RESP_DECERR         2'h3

// fields
`define CT2_ACQ_LSB         3
`define CT2_CLK_LSB         0
`define CTL_GO_BIT          0
`define STAT_DONE_BIT       0
`define ACQ_SEL_RESET       3'h0
`define CLK_SEL_RESET       3'h0
`define SAR_FIRST_TRIAL     10'h200

// timing
`define CLK_PERIOD_NS       50
`define RC_TAD_STD_NS       1200
`define RC_TAD_LP_NS        2500
`define RC_TAD_STD_CLKS     (`RC_TAD_STD_NS / `CLK_PERIOD_NS)
`define RC_TAD_LP_CLKS      (`RC_TAD_LP_NS / `CLK_PERIOD_NS)
`define INSTR_CYCLE_CLKS    4
`define CONV_TADS           11
`define RECOVER_TADS        2

`endif

// file: rtl/adc_seq_pkg.sv
/*
 * Types of the converter sequencer: state encoding and the state record.
 * Assumes adc_seq_params.svh is on the include path.
 */
`include "adc_seq_params.svh"

package adc_seq_pkg;

    typedef enum logic [4:0] {
        ST_IDLE     = 5'b00001,
        ST_RC_DELAY = 5'b00010,
        ST_ACQ      = 5'b00100,
        ST_CONV     = 5'b01000,
        ST_RECOVER  = 5'b10000
    } seq_state_t;

    typedef struct packed {
        seq_state_t                 state;
        logic                       go;
        logic                       done_flag;
        logic [2:0]                 acq_sel;
        logic [2:0]                 clk_sel;
        logic [2:0]                 lat_acq;
        logic [2:0]                 lat_clk;
        logic [7:0]                 div_cnt;
        logic [4:0]                 tad_cnt;
        logic [2:0]                 dly_cnt;
        logic [9:0]                 sar;
        logic [9:0]                 result;
        logic                       hold_connect;
        logic                       comp_s1;
        logic                       comp_s2;
        logic                       awready;
        logic                       wready;
        logic                       aw_got;
        logic                       w_got;
        logic [`AXI_ADDR_W-1:0]     waddr;
        logic [31:0]                wdata;
        logic [3:0]                 wstrb;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       arready;
        logic                       rvalid;
        logic [1:0]                 rresp;
        logic [31:0]                rdata;
    } seq_regs_t;

endpackage : adc_seq_pkg

// file: test/adc_acquire_convert_sequencer_bench.sv
/*
 * self-checking bench of the converter sequencer, registers over AXI4-Lite.
 * assumes sample_hold_model and adc_seq_params.svh on the include path.
 */
`timescale 1ns/1ns
`include "adc_seq_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end

module adc_acquire_convert_sequencer_bench;
    logic                   aclk = 1'b0, aresetn = 1'b0;
    logic [`AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0]            wdata = '0, rdata, rdat;
    logic [3:0]             wstrb = '0;
    logic                   awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic                   awready, wready, bvalid, arready, rvalid, comp_in, hold_connect, conv_busy;
    logic [1:0]             bresp, rresp, brsp, rrsp;
    logic [9:0]             dac_code, vin = 10'h000;
    int                     err_total = 0, num_checks = 0, cyc = 0;
    int                     acq_tab [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    logic [2:0]             cs_tab [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};

    adc_acquire_convert_sequencer i_adc_acquire_convert_sequencer (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .comp_in(comp_in), .hold_connect(hold_connect), .dac_code(dac_code),
        .conv_busy(conv_busy));

    sample_hold_model i_sample_hold_model (.aclk(aclk), .hold_connect(hold_connect), .dac_code(dac_code),
        .vin(vin), .comp_in(comp_in));

    always #25 aclk = ~aclk;

    // cycle count, also cuts a hang short
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [`AXI_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'h1;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        brsp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [`AXI_ADDR_W-1:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rdat = rdata;
        rrsp = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic reg_checks();
        `CHK(hold_connect, 1'b1)
        rd(`ADDR_CONTROL_TWO);
        `CHK(rdat, 32'h0000_0000)
        rd(12'h010);
        `CHK(rrsp, `RESP_DECERR)
        wr(12'h010, 32'h0000_0001);
        `CHK(brsp, `RESP_DECERR)
        wr(`ADDR_RESULT, 32'h0000_03FF);
        rd(`ADDR_RESULT);
        `CHK(rdat, 32'h0000_0000)
    endtask : reg_checks

    // one conversion: timing, sampling switch, recovery, result and flags
    task automatic conv(input logic [2:0] acq, input logic [2:0] cs, input int n_tad, input int pre,
                        input logic [9:0] v, input bit poke);
        int   t0;
        logic h1;
        vin <= v;
        wr(`ADDR_CONTROL_TWO, {26'h0, acq, cs});
        wr(`ADDR_CONTROL, 32'h0000_0001);
        t0 = cyc;
        @(posedge aclk);
        h1 = hold_connect;
        if (pre == 0)
            `CHK(h1, acq != 3'h0)
        if (poke)
            wr(`ADDR_CONTROL_TWO, {26'h0, 3'h7, cs});
        while (conv_busy === 1'b1)
            @(posedge aclk);
        `CHK(cyc - t0, 1 + pre + (acq_tab[acq] + `CONV_TADS) * n_tad)
        t0 = cyc;
        while (hold_connect !== 1'b1)
            @(posedge aclk);
        `CHK(cyc - t0, `RECOVER_TADS * n_tad)
        rd(`ADDR_RESULT);
        `CHK(rdat, {22'h0, v})
        rd(`ADDR_STATUS);
        `CHK(rdat, 32'h0000_0001)
        rd(`ADDR_CONTROL);
        `CHK(rdat, 32'h0000_0000)
        wr(`ADDR_STATUS, 32'h0000_0001);
        rd(`ADDR_STATUS);
        `CHK(rdat, 32'h0000_0000)
    endtask : conv

    // go cleared mid-conversion: no result, no done
    task automatic abort_conv(input logic [9:0] prev);
        vin <= 10'h0F0;
        wr(`ADDR_CONTROL_TWO, 32'h0000_0006);
        wr(`ADDR_CONTROL, 32'h0000_0001);
        repeat (100) @(posedge aclk);
        wr(`ADDR_CONTROL, 32'h0000_0000);
        rd(`ADDR_STATUS);
        `CHK(rdat, 32'h0000_0000)
        rd(`ADDR_RESULT);
        `CHK(rdat, {22'h0, prev})
        `CHK(conv_busy, 1'b0)
    endtask : abort_conv

    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        reg_checks();
        for (int i = 0; i < 6; i++)
            conv(3'h0, cs_tab[i], 2 << i, 0, (i == 0) ? 10'h3FF : 10'(i * 204 + 3), i == 2);
        for (int a = 1; a < 8; a++)
            conv(3'(a), 3'h4, 4, 0, 10'(a * 146), a == 7);
        conv(3'h0, 3'h3, `RC_TAD_STD_CLKS, `INSTR_CYCLE_CLKS, 10'h155, 1'b0);
        conv(3'h0, 3'h7, `RC_TAD_STD_CLKS, `INSTR_CYCLE_CLKS, 10'h2AA, 1'b0);
        abort_conv(10'h2AA);
        print_verdict();
    end
endmodule : adc_acquire_convert_sequencer_bench

// file: test/sample_hold_model.sv
/*
 * behavioural sample-and-hold with ideal comparator.
 * assumes hold_connect high means sampling and aclk as the sequencer's clock.
 */
`timescale 1ns/1ns

module sample_hold_model
(
    // from sequencer
    input  wire logic       aclk,
    input  wire logic       hold_connect,
    input  wire logic [9:0] dac_code,
    // selected channel level, in codes
    input  wire logic [9:0] vin,
    // comparator
    output      logic       comp_in
);
    logic [9:0] held_reg = 10'h000;

    // tracks the channel only while connected
    always @(posedge aclk)
    begin
        if (hold_connect)
            held_reg <= vin;
    end

    assign comp_in = (held_reg >= dac_code);
endmodule : sample_hold_model
